// file: ols_defs.svh
// Constants of the output level serial slave
`ifndef OLS_DEFS_SVH
`define OLS_DEFS_SVH

// ------------------------------------------------------------
// Addresses
// ------------------------------------------------------------
`define OLS_SLAVE_WRITE_ADDR 8'h10
`define OLS_LEVEL_WORD_ADDR 8'h00

// ------------------------------------------------------------
// Level register fields and reset values
// ------------------------------------------------------------
`define OLS_CODE_MSB 5
`define OLS_GUARD_MSB 7
`define OLS_GUARD_LSB 6
`define OLS_LEVEL_CODE_MAX 6'h28
`define OLS_LEVEL_CODE_RESET 6'h00
`define OLS_BASE_MV 13'h05DC
`define OLS_STEP_MV 13'h0064

// ------------------------------------------------------------
// Bit slots within one byte
// ------------------------------------------------------------
`define OLS_LAST_DATA_BIT 4'h7
`define OLS_ACK_BIT 4'h8

`endif

// file: ols_i2c_master_model.sv
// Behavioural two-wire bus master that drives the slave's serial pins
`timescale 1ns/1ps
module ols_i2c_master_model
(
    input wire logic baseClock, // Link timing base, 64 ns period
    input wire logic sdaWire, // Resolved data line level
    output logic scl, // Serial clock, stands high between frames
    output logic sdaPullLow // Master pulls the data line low
);
    // ------------------------------------------------------------
    // Timing: 20 base ticks per clock phase gives about 390 kbit/s
    // ------------------------------------------------------------
    localparam int QUARTER = 10;
    initial
    begin
        scl = 1'b1;
        sdaPullLow = 1'b0;
    end
    task ticks(input int n);
        repeat (n) @(posedge baseClock);
    endtask : ticks
    // Also serves as repeated START, since it first releases data while the clock is low
    task bus_start;
        ticks(QUARTER);
        sdaPullLow = 1'b0;
        ticks(QUARTER);
        scl = 1'b1;
        ticks(QUARTER);
        sdaPullLow = 1'b1;
        ticks(QUARTER);
        scl = 1'b0;
    endtask : bus_start
    task bus_stop;
        ticks(QUARTER);
        sdaPullLow = 1'b1;
        ticks(QUARTER);
        scl = 1'b1;
        ticks(QUARTER);
        sdaPullLow = 1'b0;
        ticks(2 * QUARTER);
    endtask : bus_stop
    task send_byte(input logic [7:0] value, output logic ack, output logic clash);
        logic early;
        clash = 1'b0;
        for (int i = 7; i >= 0; i--)
        begin
            ticks(QUARTER);
            sdaPullLow = ~value[i];
            ticks(QUARTER);
            scl = 1'b1;
            ticks(QUARTER);
            // A released bit read low means the slave drove outside its slot
            if (value[i] && sdaWire !== 1'b1)
                clash = 1'b1;
            ticks(QUARTER);
            scl = 1'b0;
        end
        ticks(QUARTER);
        sdaPullLow = 1'b0;
        ticks(QUARTER);
        scl = 1'b1;
        ticks(1);
        early = sdaWire;
        ticks(2 * QUARTER - 2);
        ack = (early === 1'b0) && (sdaWire === 1'b0);
        ticks(1);
        scl = 1'b0;
    endtask : send_byte
endmodule : ols_i2c_master_model

// file: ols_i2c_slave.sv
// Receive-only two-wire slave that sets the converter output level code
`timescale 1ns/1ps
`include "ols_defs.svh"
// Operation
// - With no transfer running, both lines rest released high.
// - Data falling while clock high is START, opening a transfer.
// - Data rising while clock high is STOP, ending a transfer.
// - One bit per clock pulse; data changes only while clock low.
// - Every eight bits are followed by a ninth acknowledge slot.
// - Any number of data bytes is accepted between START and STOP.
// - Once addressed, every received byte is acknowledged.
// - Acknowledger holds data low through the whole acknowledge clock high.
// - Byte sender releases data during the acknowledge slot.
// - Missing master acknowledge marks last byte; sender keeps data released.
// - First byte after every START is the slave address.
// - Respond only to address byte 10h, a write.
// - Receive only; clock is input; data driven only low for acknowledges.
// - Byte after address is the word address; level register at 00h.
// - Word address advances after each data byte.
// - Operate at bit rates up to 400 kbit/s.
// - Level byte has zero bits 7 and 6 and a 6-bit code.
// - Code n from 0 to 40 selects 1.5 V plus n times 0.1 V.
// - Serial value takes over the target only after start-up.
module ols_i2c_slave
(
    input wire logic clock, // System clock
    input wire logic srst, // Synchronous reset, active high
    input wire logic serialClock, // Serial clock pin, link domain
    input wire logic sdaIn, // Serial data pin level
    output logic sdaOut, // Serial data drive value, always low
    output logic sdaOe, // Serial data pull-down enable
    input wire logic startupDone, // Converter start-up finished
    output ols_pkg::ols_level_type levelOut, // Target level and control source
    output logic busBusy // Transfer in progress
);

    // ------------------------------------------------------------
    // Link clock domain
    // ------------------------------------------------------------
    // The master changes data only while the clock is low, so the
    // data pin is already settled at each rising clock edge here.
    // These flops carry no reset because the link clock stands still
    // outside frames; the system side never trusts their first value.
    logic linkBit = 1'b1;
    logic linkTog = 1'b0;

    always_ff @(posedge serialClock)
    begin
        linkBit <= sdaIn;
        linkTog <= ~linkTog;
    end

    // ------------------------------------------------------------
    // Synchronisers into the system domain
    // ------------------------------------------------------------
    // Three system cycles of delay stay far below the shortest bit
    // time at the top bit rate, so no bit is missed.
    ols_pkg::ols_pins_type pinMeta;
    ols_pkg::ols_pins_type pinSync;
    ols_pkg::ols_pins_type pinLast;
    logic togMeta;
    logic togSync;
    logic togLast;

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            pinMeta <= 2'h3;
            pinSync <= 2'h3;
            pinLast <= 2'h3;
            togMeta <= 1'b0;
            togSync <= 1'b0;
            togLast <= 1'b0;
        end
        else
        begin
            pinMeta <= '{scl: serialClock, sda: sdaIn};
            pinSync <= pinMeta;
            pinLast <= pinSync;
            togMeta <= linkTog;
            togSync <= togMeta;
            togLast <= togSync;
        end
    end

    // ------------------------------------------------------------
    // Line events
    // ------------------------------------------------------------
    ols_pkg::ols_state_type state;
    ols_pkg::ols_state_type next_state;
    logic [3:0] bitCnt;
    logic [7:0] shiftReg;
    logic [7:0] wordAddr;
    logic byteDone;
    logic ackWanted;

    wire sclHigh = pinSync.scl && pinLast.scl;
    wire startSeen = sclHigh && pinLast.sda && !pinSync.sda;
    wire stopSeen = sclHigh && !pinLast.sda && pinSync.sda;
    wire frameEdge = startSeen || stopSeen;
    wire sclFall = pinLast.scl && !pinSync.scl;
    wire inFrame = (state != ols_pkg::OLS_IDLE);
    wire bitEv = (togSync != togLast) && inFrame;
    wire ackSlot = (bitCnt == `OLS_ACK_BIT);
    wire [7:0] next_shiftReg = {shiftReg[6:0], linkBit};

    // ------------------------------------------------------------
    // Byte decode
    // ------------------------------------------------------------
    wire addrMatch = (shiftReg == `OLS_SLAVE_WRITE_ADDR);
    wire guardZero = (shiftReg[`OLS_GUARD_MSB:`OLS_GUARD_LSB] == 2'h0);
    wire codeValid = guardZero && (shiftReg[`OLS_CODE_MSB:0] <= `OLS_LEVEL_CODE_MAX);
    wire levelHit = (wordAddr == `OLS_LEVEL_WORD_ADDR);
    wire dataByte = byteDone && !frameEdge && (state == ols_pkg::OLS_DATA);
    wire levelWrite = dataByte && levelHit && codeValid && startupDone;
    wire [12:0] next_targetMv = `OLS_BASE_MV + `OLS_STEP_MV * {7'h00, shiftReg[`OLS_CODE_MSB:0]};

    always_comb
    begin
        next_state = state;
        if (startSeen)
        begin
            next_state = ols_pkg::OLS_ADDR;
        end
        else if (stopSeen)
        begin
            next_state = ols_pkg::OLS_IDLE;
        end
        else if (byteDone)
        begin
            unique case (state)
                ols_pkg::OLS_IDLE:
                    next_state = ols_pkg::OLS_IDLE;
                ols_pkg::OLS_ADDR:
                    next_state = addrMatch ? ols_pkg::OLS_WADDR : ols_pkg::OLS_IGNORE;
                ols_pkg::OLS_WADDR:
                    next_state = ols_pkg::OLS_DATA;
                ols_pkg::OLS_DATA:
                    next_state = ols_pkg::OLS_DATA;
                ols_pkg::OLS_IGNORE:
                    next_state = ols_pkg::OLS_IGNORE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Frame state
    // ------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            state <= ols_pkg::OLS_IDLE;
        end
        else
        begin
            state <= next_state;
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst || frameEdge)
        begin
            bitCnt <= 4'h0;
        end
        else if (bitEv)
        begin
            bitCnt <= ackSlot ? 4'h0 : bitCnt + 4'h1;
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            shiftReg <= 8'h00;
        end
        else if (bitEv && !ackSlot)
        begin
            shiftReg <= next_shiftReg;
        end
    end

    // A byte is whole one cycle after its eighth bit lands
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            byteDone <= 1'b0;
        end
        else
        begin
            byteDone <= bitEv && !frameEdge && (bitCnt == `OLS_LAST_DATA_BIT);
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst || frameEdge)
        begin
            ackWanted <= 1'b0;
        end
        else if (byteDone)
        begin
            unique case (state)
                ols_pkg::OLS_ADDR:
                    ackWanted <= addrMatch;
                ols_pkg::OLS_WADDR, ols_pkg::OLS_DATA:
                    ackWanted <= 1'b1;
                ols_pkg::OLS_IDLE, ols_pkg::OLS_IGNORE:
                    ackWanted <= 1'b0;
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            wordAddr <= 8'h00;
        end
        else if (byteDone && !frameEdge && state == ols_pkg::OLS_WADDR)
        begin
            wordAddr <= shiftReg;
        end
        else if (dataByte)
        begin
            wordAddr <= wordAddr + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // Data line drive
    // ------------------------------------------------------------
    // The pull-down changes only on a falling clock, so it is settled
    // before the acknowledge clock rises and holds through its high.
    always_ff @(posedge clock)
    begin
        if (srst || frameEdge)
        begin
            sdaOe <= 1'b0;
        end
        else if (sclFall)
        begin
            sdaOe <= ackSlot && ackWanted;
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            sdaOut <= 1'b0;
            busBusy <= 1'b0;
        end
        else
        begin
            sdaOut <= 1'b0;
            busBusy <= (next_state != ols_pkg::OLS_IDLE);
        end
    end

    // ------------------------------------------------------------
    // Level register
    // ------------------------------------------------------------
    // Until a serial write lands the external divider sets the target,
    // which serialControl low tells the converter.
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            levelOut.code <= `OLS_LEVEL_CODE_RESET;
            levelOut.targetMv <= `OLS_BASE_MV;
            levelOut.serialControl <= 1'b0;
        end
        else if (levelWrite)
        begin
            levelOut.code <= shiftReg[`OLS_CODE_MSB:0];
            levelOut.targetMv <= next_targetMv;
            levelOut.serialControl <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);

    sequence seqAckStart;
        $rose(sdaOe);
    endsequence

    sequence seqAckHold;
        sdaOe [*8];
    endsequence

    sequence seqDataByte;
        byteDone && !frameEdge && state == ols_pkg::OLS_DATA;
    endsequence

    chk_idle_released: assert property (state == ols_pkg::OLS_IDLE |-> !sdaOe && !busBusy)
        else $error("data line driven while idle");
    chk_start_opens: assert property (startSeen |=> state == ols_pkg::OLS_ADDR && bitCnt == 4'h0)
        else $error("start did not open address phase");
    chk_stop_closes: assert property (stopSeen |=> state == ols_pkg::OLS_IDLE && !sdaOe ##1 !busBusy)
        else $error("stop did not end transfer");
    chk_bit_count: assert property (bitEv && !frameEdge && !ackSlot |=> bitCnt == $past(bitCnt) + 4'h1)
        else $error("bit not counted");
    chk_ack_slot: assert property (seqAckStart |-> ackSlot && ackWanted && !pinSync.scl)
        else $error("pull-down outside acknowledge slot");
    chk_ack_hold: assert property (seqAckStart |-> seqAckHold)
        else $error("acknowledge released early");
    chk_addr_ack: assert property (byteDone && !frameEdge && state == ols_pkg::OLS_ADDR
        |=> ackWanted == $past(addrMatch))
        else $error("address acknowledge wrong");
    chk_data_ack: assert property (byteDone && !frameEdge
        && state inside {ols_pkg::OLS_WADDR, ols_pkg::OLS_DATA} |=> ackWanted && state == ols_pkg::OLS_DATA)
        else $error("addressed byte not acknowledged");
    chk_word_step: assert property (seqDataByte |=> wordAddr == $past(wordAddr) + 8'h01)
        else $error("word address did not advance");
    chk_level_map: assert property (levelWrite |=> levelOut.code == $past(shiftReg[5:0])
        && levelOut.targetMv == `OLS_BASE_MV + `OLS_STEP_MV * {7'h00, levelOut.code})
        else $error("level code or target wrong");
    chk_bad_kept: assert property (seqDataByte ##0 (!codeValid || !levelHit || !startupDone)
        |=> $stable(levelOut))
        else $error("invalid write changed level");
    chk_ignore_quiet: assert property (state == ols_pkg::OLS_IGNORE |-> !ackWanted ##1 !sdaOe)
        else $error("foreign traffic acknowledged");

endmodule : ols_i2c_slave

// file: ols_i2c_slave_tb.sv
// Self-checking testbench of the output level serial slave
`timescale 1ns/1ps
module ols_i2c_slave_tb;
    logic clock;
    logic srst;
    logic baseClock;
    logic sclLine;
    logic masterLow;
    logic sdaWire;
    logic startupDone;
    logic sdaOut;
    logic sdaOe;
    logic busBusy;
    logic [5:0] expCode;
    ols_pkg::ols_level_type levelOut;
    int failures;
    int checked;
    logic [7:0] codeList [7] = '{8'h00, 8'h28, 8'h29, 8'h3F, 8'h45, 8'h81, 8'h13};
    logic [7:0] addrList [3] = '{8'h11, 8'h20, 8'h90};
    // Pull-up: the line is low only while somebody pulls it
    assign sdaWire = (masterLow || (sdaOe && !sdaOut)) ? 1'b0 : 1'b1;
    ols_i2c_slave i_dut
    (
        .clock(clock),
        .srst(srst),
        .serialClock(sclLine),
        .sdaIn(sdaWire),
        .sdaOut(sdaOut),
        .sdaOe(sdaOe),
        .startupDone(startupDone),
        .levelOut(levelOut),
        .busBusy(busBusy)
    );
    ols_i2c_master_model i_master
    (
        .baseClock(baseClock),
        .sdaWire(sdaWire),
        .scl(sclLine),
        .sdaPullLow(masterLow)
    );
    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    initial
    begin
        baseClock = 1'b0;
        #7;
        forever #32 baseClock = ~baseClock;
    end
    // ------------------------------------------------------------
    // Checking and bus tasks
    // ------------------------------------------------------------
    task tally_and_finish;
        if (failures == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish
    task check(input logic ok, input string msg);
        checked++;
        if (ok !== 1'b1)
        begin
            failures++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask : check
    task check_level(input logic [5:0] code, input logic ctl);
        ols_pkg::ols_level_type e;
        e.code = code;
        e.targetMv = 13'h05DC + 13'h0064 * 13'(code);
        e.serialControl = ctl;
        check(levelOut === e, "level output wrong");
    endtask : check_level
    task send(input logic [7:0] value, input logic ackExp);
        logic ack;
        logic clash;
        i_master.send_byte(value, ack, clash);
        check(ack === ackExp, "acknowledge wrong");
        check(clash === 1'b0, "data line pulled outside acknowledge");
    endtask : send
    task begin_frame;
        i_master.bus_start();
        check(busBusy === 1'b1, "start not seen");
    endtask : begin_frame
    task end_frame;
        i_master.bus_stop();
        check(busBusy === 1'b0, "stop not seen");
        check(sdaWire === 1'b1 && sclLine === 1'b1 && sdaOe === 1'b0, "bus not idle");
    endtask : end_frame
    task level_write(input logic [7:0] value);
        begin_frame();
        send(8'h10, 1'b1);
        send(8'h00, 1'b1);
        send(value, 1'b1);
        end_frame();
    endtask : level_write
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        failures = 0;
        checked = 0;
        srst = 1'b1;
        startupDone = 1'b0;
        repeat (10) @(posedge clock);
        #2 srst = 1'b0;
        repeat (4) @(posedge clock);
        check_level(6'h00, 1'b0);
        check(sdaOe === 1'b0 && busBusy === 1'b0, "outputs after reset");
        // Writes before start-up are acknowledged but leave the divider in charge
        level_write(8'h0A);
        check_level(6'h00, 1'b0);
        @(posedge clock);
        #2 startupDone = 1'b1;
        // Second data byte lands at word address 01h and is dropped
        begin_frame();
        send(8'h10, 1'b1);
        send(8'h00, 1'b1);
        send(8'h0A, 1'b1);
        check_level(6'h0A, 1'b1);
        send(8'h05, 1'b1);
        end_frame();
        check_level(6'h0A, 1'b1);
        expCode = 6'h0A;
        for (int k = 0; k < 7; k++)
        begin
            level_write(codeList[k]);
            if (codeList[k][7:6] == 2'b00 && codeList[k][5:0] <= 6'h28)
                expCode = codeList[k][5:0];
            check_level(expCode, 1'b1);
        end
        for (int k = 0; k < 3; k++)
        begin
            begin_frame();
            send(addrList[k], 1'b0);
            send(8'hFF, 1'b0);
            end_frame();
            check_level(expCode, 1'b1);
        end
        // Word address FFh wraps to 00h after one dropped byte
        begin_frame();
        send(8'h10, 1'b1);
        send(8'hFF, 1'b1);
        send(8'h03, 1'b1);
        send(8'h07, 1'b1);
        check_level(6'h07, 1'b1);
        begin_frame();
        send(8'h00, 1'b0);
        begin_frame();
        send(8'h10, 1'b1);
        send(8'h00, 1'b1);
        send(8'h15, 1'b1);
        end_frame();
        check_level(6'h15, 1'b1);
        tally_and_finish();
    end
endmodule : ols_i2c_slave_tb

// file: ols_pkg.sv
// Types of the output level serial slave
package ols_pkg;

    typedef enum logic [2:0]
    {
        OLS_IDLE,
        OLS_ADDR,
        OLS_WADDR,
        OLS_DATA,
        OLS_IGNORE
    } ols_state_type;

    typedef struct packed
    {
        logic scl;
        logic sda;
    } ols_pins_type;

    typedef struct packed
    {
        logic [5:0] code;
        logic [12:0] targetMv;
        logic serialControl;
    } ols_level_type;

endpackage : ols_pkg
